// ===== rtl/sacp_defines.vh
// constants of the serial converter read-out port
// assumes a 100 MHz core clock; times are in nanoseconds
`ifndef SACP_DEFINES_VH
`define SACP_DEFINES_VH

// ****************************************
// clock and timing
// ****************************************
`define SACP_CLK_PERIOD_NS 10
`define SACP_CONV_TIME_NS 7500
`define SACP_CONV_CYCLES (`SACP_CONV_TIME_NS / `SACP_CLK_PERIOD_NS)
`define SACP_RESULT_BITS 12

// ****************************************
// power-down level codes
// ****************************************
`define SACP_PD_LOW 2'h0
`define SACP_PD_MID 2'h1
`define SACP_PD_HIGH 2'h2

`endif

// ===== rtl/sacp_sync3.v
// three-flop synchroniser with agreement filter for one pin input
// assumes the pin is asynchronous to core_clk_in
`timescale 1ns/100ps
module sacp_sync3 #(
	parameter RESET_VAL = 1'b0
) (
	// clock and reset
	input wire core_clk_in,
	input wire nrst_in,
	// pin side
	input wire pin_in,
	// filtered level
	output reg level_out
);
	reg s1_q;
	reg s2_q;
	reg s3_q;

	always @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			s1_q <= RESET_VAL;
			s2_q <= RESET_VAL;
			s3_q <= RESET_VAL;
			level_out <= RESET_VAL;
		end else begin
			s1_q <= pin_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
			// a change counts once the second and third stages agree
			if (s2_q == s3_q) begin
				level_out <= s3_q;
			end
		end
	end
endmodule

// ===== rtl/sacp_port.v
// conversion control and three-wire serial read-out port
// assumes a host drives select and shift clock; sample comes from the analog core
`timescale 1ns/100ps
`include "sacp_defines.vh"
module sacp_port #(
	parameter RESULT_BITS = `SACP_RESULT_BITS,
	parameter CONV_CYCLES = `SACP_CONV_CYCLES
) (
	// clock and reset
	input wire core_clk_in,
	input wire nrst_in,
	// host pins
	input wire select_n_in,
	input wire shift_clk_in,
	output reg serial_data_out,
	output reg serial_data_oe_n_out,
	// power-down three-level input, decoded
	input wire power_down_level_input_low_in,
	input wire power_down_level_input_high_in,
	// analog core
	input wire [RESULT_BITS-1:0] analog_input_code_in,
	output reg sample_hold_out,
	output reg int_ref_en_out,
	output reg operational_out
);
	// ****************************************
	// sequencer states and timer end
	// ****************************************
	localparam [1:0] ST_IDLE = 2'h0;
	localparam [1:0] ST_CONV = 2'h1;
	localparam [1:0] ST_SHIFT = 2'h2;
	localparam [31:0] CONV_LAST = CONV_CYCLES - 1;

	// ****************************************
	// pin synchronisers
	// ****************************************
	wire sel_n_s;
	wire sclk_s;
	wire pd_low_s;
	wire pd_high_s;
	reg sel_n_q;
	reg sclk_q;
	reg [1:0] state_q;
	reg [1:0] state_d;
	reg [31:0] cnt_q;
	reg [31:0] cnt_d;
	reg [RESULT_BITS:0] shreg_q;
	reg [RESULT_BITS:0] shreg_d;
	reg dout_d;
	reg oe_n_d;
	reg hold_d;

	sacp_sync3 #(.RESET_VAL(1'b1)) u_sel (
		.core_clk_in(core_clk_in),
		.nrst_in(nrst_in),
		.pin_in(select_n_in),
		.level_out(sel_n_s)
	);
	sacp_sync3 #(.RESET_VAL(1'b0)) u_sclk (
		.core_clk_in(core_clk_in),
		.nrst_in(nrst_in),
		.pin_in(shift_clk_in),
		.level_out(sclk_s)
	);
	sacp_sync3 #(.RESET_VAL(1'b0)) u_pdl (
		.core_clk_in(core_clk_in),
		.nrst_in(nrst_in),
		.pin_in(power_down_level_input_low_in),
		.level_out(pd_low_s)
	);
	sacp_sync3 #(.RESET_VAL(1'b0)) u_pdh (
		.core_clk_in(core_clk_in),
		.nrst_in(nrst_in),
		.pin_in(power_down_level_input_high_in),
		.level_out(pd_high_s)
	);

	// ****************************************
	// edge detection on the synchronised pins
	// ****************************************
	// previous levels reset to the idle pin levels, so leaving reset never
	// looks like a select or shift-clock edge
	always @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			sel_n_q <= 1'b1;
			sclk_q <= 1'b0;
		end else begin
			sel_n_q <= sel_n_s;
			sclk_q <= sclk_s;
		end
	end

	wire sel_fall = sel_n_q & ~sel_n_s;
	wire sclk_fall = sclk_q & ~sclk_s;

	// ****************************************
	// power-down level decoding
	// ****************************************
	// both decoded lines high cannot come from a real pin; it is taken as the
	// open level: operational, internal reference off
	function [1:0] pd_level;
		input lo;
		input hi;
		begin
			if (lo && !hi) begin
				pd_level = `SACP_PD_LOW;
			end else if (hi && !lo) begin
				pd_level = `SACP_PD_HIGH;
			end else begin
				pd_level = `SACP_PD_MID;
			end
		end
	endfunction

	wire [1:0] pd_lvl = pd_level(pd_low_s, pd_high_s);
	wire shutdown = (pd_lvl == `SACP_PD_LOW);
	wire ref_on = (pd_lvl == `SACP_PD_HIGH);

	// ****************************************
	// mode outputs
	// ****************************************
	// the sequencer only looks at shutdown when a conversion starts; one already running completes
	always @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			operational_out <= 1'b0;
			int_ref_en_out <= 1'b0;
		end else begin
			operational_out <= ~shutdown;
			int_ref_en_out <= ref_on;
		end
	end

	// ****************************************
	// sequencer next state
	// ****************************************
	// outputs hold their value unless a phase below changes them
	always @* begin
		state_d = state_q;
		cnt_d = cnt_q;
		shreg_d = shreg_q;
		dout_d = serial_data_out;
		oe_n_d = serial_data_oe_n_out;
		hold_d = sample_hold_out;
		if (sel_n_s) begin
			// a high select aborts any phase and releases the line
			state_d = ST_IDLE;
			oe_n_d = 1'b1;
			dout_d = 1'b0;
			hold_d = 1'b0;
		end else begin
			case (state_q)
				ST_IDLE: begin
					// a select fall in shutdown is dropped; the host must start again
					if (sel_fall && !shutdown) begin
						state_d = ST_CONV;
						cnt_d = 32'h0;
						hold_d = 1'b1;
						oe_n_d = 1'b0;
						dout_d = 1'b0;
					end
				end
				ST_CONV: begin
					// the timer alone ends the conversion; shift-clock edges are ignored
					if (cnt_q >= CONV_LAST) begin
						state_d = ST_SHIFT;
						shreg_d = {analog_input_code_in, 1'b0};
						dout_d = 1'b1;
						hold_d = 1'b0;
					end else begin
						cnt_d = cnt_q + 32'h1;
					end
				end
				ST_SHIFT: begin
					// past the last result bit only zeros remain in the register
					if (sclk_fall) begin
						dout_d = shreg_q[RESULT_BITS];
						shreg_d = {shreg_q[RESULT_BITS-1:0], 1'b0};
					end
				end
				default: begin
					state_d = ST_IDLE;
				end
			endcase
		end
	end

	// ****************************************
	// sequencer registers
	// ****************************************
	always @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			state_q <= ST_IDLE;
			cnt_q <= 32'h0;
			shreg_q <= {(RESULT_BITS+1){1'b0}};
			serial_data_out <= 1'b0;
			serial_data_oe_n_out <= 1'b1;
			sample_hold_out <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			shreg_q <= shreg_d;
			serial_data_out <= dout_d;
			serial_data_oe_n_out <= oe_n_d;
			sample_hold_out <= hold_d;
		end
	end
endmodule

// ===== bench/sacp_port_props.sv
// pin-level assertions for the converter read-out port
// assumes it is bound into every sacp_port instance
`timescale 1ns/100ps
module sacp_port_props #(
	parameter CONV_CYCLES = 750
) (
	// clock and reset
	input wire core_clk_in,
	input wire nrst_in,
	// host pins
	input wire select_n_in,
	input wire shift_clk_in,
	input wire serial_data_out,
	input wire serial_data_oe_n_out,
	// power-down and analog core
	input wire power_down_level_input_low_in,
	input wire power_down_level_input_high_in,
	input wire sample_hold_out,
	input wire int_ref_en_out,
	input wire operational_out
);
	localparam int CL = CONV_CYCLES - 1;
	localparam int CH = CONV_CYCLES + 2;
	wire cs = select_n_in;
	wire oen = serial_data_oe_n_out;
	wire d = serial_data_out;
	wire sh = sample_hold_out;
	wire op = operational_out;
	wire lo = power_down_level_input_low_in;
	wire hi = power_down_level_input_high_in;
	wire sck = shift_clk_in;
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!nrst_in);
	hiz_idle_a: assert property (cs[*8] |-> oen) else $error("output driven while deselected");
	hiz_end_a: assert property ($rose(cs) |-> ##[3:8] oen) else $error("output not released");
	conv_start_a: assert property ($fell(cs) && op && oen && !sh
		|-> ##[3:8] !oen && sh && !d) else $error("conversion start wrong");
	shut_refuse_a: assert property ($fell(cs) && lo && !op |-> oen[*8])
		else $error("started in shutdown");
	conv_time_a: assert property ($rose(sh) |-> ##[CL:CH] ($rose(d) && !sh))
		else $error("end of conversion mistimed");
	shift_edge_a: assert property ($changed(d) && !oen |-> !sck && !$past(sck, 3))
		else $error("data moved off a falling shift edge");
	mode_op_a: assert property ($stable({lo, hi})[*8] |-> op == !(lo && !hi))
		else $error("operational wrong");
	mode_ref_a: assert property ($stable({lo, hi})[*8] |-> int_ref_en_out == (hi && !lo))
		else $error("reference enable wrong");
endmodule
bind sacp_port sacp_port_props #(.CONV_CYCLES(CONV_CYCLES)) u_props(.core_clk_in, .nrst_in,
	.select_n_in, .shift_clk_in, .serial_data_out, .serial_data_oe_n_out, .sample_hold_out,
	.power_down_level_input_low_in, .power_down_level_input_high_in, .int_ref_en_out,
	.operational_out);

// ===== bench/sacp_host.sv
// host model: drives select and shift clock, reads the serial stream
// assumes a released data line reads as the inverse of its last value
`timescale 1ns/100ps
module sacp_host (
	// serial line from the port
	input wire d_in,
	input wire oe_n_in,
	// host-driven pins
	output reg cs_n_out,
	output reg sck_out
);
	reg dl = 1'b1;
	wire dw = oe_n_in ? ~dl : d_in;
	integer i;
	initial begin
		cs_n_out = 1'b1;
		sck_out = 1'b0;
	end
	task xfer(input integer n, output reg [14:0] v);
		begin
			v = 15'h0;
			#100 cs_n_out = 1'b0;
			#100;
			for (i = 0; i < 300 && dw !== 1'b1; i = i + 1) #10;
			for (i = 0; i < n; i = i + 1) begin
				#250 sck_out = 1'b1;
				v = {v[13:0], dw};
				dl = dw;
				#250 sck_out = 1'b0;
			end
			#250 cs_n_out = 1'b1;
			#2000;
		end
	endtask
endmodule

// ===== bench/sacp_port_test.sv
// self-checking bench for the converter read-out port
// assumes sacp_host plays the controller; short conversion of 20 cycles
`timescale 1ns/100ps
module sacp_port_test;
	reg core_clk_in = 1'b0;
	reg nrst_in = 1'b0;
	reg power_down_level_input_low_in = 1'b0;
	reg power_down_level_input_high_in = 1'b1;
	reg [11:0] analog_input_code_in = 12'h000;
	wire select_n_in, shift_clk_in, serial_data_out, serial_data_oe_n_out;
	wire sample_hold_out, int_ref_en_out, operational_out;
	wire [2:0] start_vis = {sample_hold_out, serial_data_oe_n_out, serial_data_out};
	integer failures = 0, n_compared = 0, cyc = 0;
	reg [14:0] v;
	always #5 core_clk_in = ~core_clk_in;
	sacp_port #(.CONV_CYCLES(20)) u_dut(.core_clk_in, .nrst_in, .select_n_in, .shift_clk_in,
		.serial_data_out, .serial_data_oe_n_out, .power_down_level_input_low_in,
		.power_down_level_input_high_in, .analog_input_code_in, .sample_hold_out,
		.int_ref_en_out, .operational_out);
	sacp_host u_host(.d_in(serial_data_out), .oe_n_in(serial_data_oe_n_out),
		.cs_n_out(select_n_in), .sck_out(shift_clk_in));
	task finish_test;
		begin
			$display("counts: %0d compared, %0d failed", n_compared, failures);
			if (failures == 0 && n_compared > 0) $display("TB: PASS");
			else $display("TB: FAIL");
			$finish;
		end
	endtask
	task chk(input string s, input [14:0] seen, input [14:0] exp);
		begin
			n_compared = n_compared + 1;
			if (seen !== exp) begin
				failures = failures + 1;
				$display("CHECK FAILED %s expected %h seen %h", s, exp, seen);
			end
		end
	endtask
	task t_read(input [11:0] c, input integer n);
		begin
			@(posedge core_clk_in) #1 analog_input_code_in = c;
			fork
				u_host.xfer(n, v);
				#200 chk("start", {12'h0, start_vis}, 15'h4);
			join
			chk("stream", v, {1'b1, c, 2'b00} >> (15 - n));
			chk("release", {14'h0, serial_data_oe_n_out}, 15'h1);
			$display("test read done");
		end
	endtask
	task t_mode(input lo, input hi, input [1:0] e);
		begin
			@(posedge core_clk_in) #1 power_down_level_input_low_in = lo;
			power_down_level_input_high_in = hi;
			repeat (20) @(posedge core_clk_in);
			#1 chk("mode", {13'h0, operational_out, int_ref_en_out}, {13'h0, e});
			$display("test mode done");
		end
	endtask
	task t_shut;
		begin
			t_mode(1'b1, 1'b0, 2'b00);
			fork
				u_host.xfer(0, v);
				#300 chk("shutdown", {13'h0, serial_data_oe_n_out, sample_hold_out}, 15'h2);
			join
			$display("test shutdown done");
		end
	endtask
	always @(posedge core_clk_in) begin
		cyc = cyc + 1;
		if (cyc == 10000) begin
			failures = failures + 1;
			finish_test;
		end
	end
	initial begin
		repeat (2) @(posedge core_clk_in);
		#1 nrst_in = 1;
		repeat (10) @(posedge core_clk_in);
		t_mode(1'b0, 1'b0, 2'b10);
		t_mode(1'b1, 1'b1, 2'b10);
		t_mode(1'b0, 1'b1, 2'b11);
		t_read(12'hfff, 15);
		t_read(12'h801, 5);
		t_read(12'h000, 15);
		t_read(12'h5a3, 15);
		t_shut;
		finish_test;
	end
endmodule
